// ===== logic/gate_check_pkg.sv
// Constants, field layouts and register offsets of the gate descriptor checker.
// Assumes a 128-bit gate image, low quadword first, and a 32-bit register bus.
package gate_check_pkg;
  // Gate and system descriptor type codes
  localparam logic [3:0] TYPE_ZERO = 4'h0;
  localparam logic [3:0] TYPE_SYS_ILL1 = 4'h1;
  localparam logic [3:0] TYPE_LDT = 4'h2;
  localparam logic [3:0] TYPE_SYS_ILL3 = 4'h3;
  localparam logic [3:0] TYPE_CALL16 = 4'h4;
  localparam logic [3:0] TYPE_TASK = 4'h5;
  localparam logic [3:0] TYPE_INT16 = 4'h6;
  localparam logic [3:0] TYPE_TRAP16 = 4'h7;
  localparam logic [3:0] TYPE_TSS_AVL = 4'h9;
  localparam logic [3:0] TYPE_TSS_BUSY = 4'hB;
  localparam logic [3:0] TYPE_CALL64 = 4'hC;
  localparam logic [3:0] TYPE_INT64 = 4'hE;
  localparam logic [3:0] TYPE_TRAP64 = 4'hF;
  // Field positions in the low and high quadwords
  localparam int OFS0_LSB = 0;
  localparam int SEL_LSB = 16;
  localparam int SIDX_LSB = 32;
  localparam int TYPE_LSB = 40;
  localparam int S_BIT = 44;
  localparam int OFS1_LSB = 48;
  localparam int OFS2_LSB = 0;
  localparam int HI_ZERO_LSB = 40;
  localparam int HI_ZERO_W = 5;
  // Table entry scale: vector times sixteen
  localparam int ENTRY_SHIFT = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_TBL_LO = 8'h00;
  localparam logic [7:0] OFS_TBL_HI = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_FAULT = 8'h10;
  // Status and mask bit positions
  localparam int ST_TYPE = 0;
  localparam int ST_UPPER = 1;
  localparam int ST_CANON = 2;
  localparam int ST_TARGET = 3;
  localparam int ST_SYSTEM = 4;
  localparam int ST_W = 5;
  // Reset values
  localparam logic [63:0] TBL_BASE_RST = 64'h0;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {FK_NONE, FK_TYPE, FK_UPPER, FK_CANON, FK_TARGET, FK_SYSTEM}
    fault_kind_e;
endpackage

// ===== logic/gate_checker.sv
// Long-mode gate descriptor checker with an AXI4-Lite register slave.
// Assumes requests come from core logic on aclk, one request per cycle at most.
// Summary of operation
// - Types 0Ch, 0Eh, 0Fh decode as 64-bit call, interrupt and trap gates.
// - Long mode use of gate types 04h to 07h raises a protection fault.
// - Gates span 128 bits; assemble the full 64-bit target offset.
// - Target code segment must have long flag 1, size flag 0.
// - Bad target code: selector for call gates, vector for interrupt gates.
// - Non-canonical gate offset faults with error code zero.
// - Call gate upper type bits must be zero; legacy read of it faults.
// - Interrupt table entry address is base plus vector times sixteen.
// - Three-bit stack index from low bits of byte 4; call gates lack it.
// - Nonzero stack index loads stack pointer from that task-state entry.
// - Zero stack index in an interrupt gate falls back to privilege-based stack switching.
// - Table register descriptors expand only in 64-bit mode.
// - Gates expand throughout long mode, both sub-modes.
// - System types 02h, 09h, 0Bh redefined; 01h and 03h illegal.
// - In 64-bit mode size flag 0 means 64-bit address, 32-bit data.
// - Long flag 0 selects compatibility mode, 1 selects 64-bit mode.
module gate_checker
  import gate_check_pkg::*;
#(
  parameter int VA_BITS = 48
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor mode
  input wire logic long_mode,
  input wire logic cur_cs_l,
  input wire logic cur_cs_d,
  // Gate check request
  input wire logic req_valid,
  input wire logic req_is_int,
  input wire logic [7:0] req_vector,
  input wire logic [15:0] req_gate_code,
  input wire logic [63:0] gate_lo,
  input wire logic [63:0] gate_hi,
  input wire logic target_cs_l,
  input wire logic target_cs_d,
  // System descriptor check request
  input wire logic sys_valid,
  input wire logic [3:0] sys_type,
  input wire logic [15:0] sys_selector,
  // Control transfer result
  output logic xfer_valid,
  output logic [63:0] xfer_offset,
  output logic [15:0] xfer_selector,
  output logic [2:0] xfer_sidx,
  output logic xfer_use_sidx,
  output logic xfer_legacy_stack,
  output logic [63:0] tbl_entry_addr,
  // System descriptor result
  output logic sys_done,
  output logic sys_expanded,
  // Fault report
  output logic fault_valid,
  output gate_check_pkg::fault_kind_e fault_kind,
  output logic [15:0] fault_code,
  // Mode decode
  output logic mode_64bit,
  output logic addr64_op32,
  output logic size_reserved,
  // Interrupt
  output logic irq
);
  import gate_check_pkg::*;

  if (VA_BITS < 32 || VA_BITS > 64)
  begin : g_bad_va
    $error("VA_BITS must lie in 32..64");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [63:0] tbl_base;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    fault_kind_e last_kind;
    logic [15:0] last_code;
    logic irq;
    logic xfer;
    logic [63:0] offset;
    logic [15:0] selector;
    logic [2:0] sidx;
    logic use_sidx;
    logic legacy_stack;
    logic [63:0] tbl_addr;
    logic sys_done;
    logic sys_expanded;
    logic fault;
    fault_kind_e fkind;
    logic [15:0] fcode;
    logic mode_64;
    logic a64_o32;
    logic size_rsv;
  } state_s;

  state_s st_reg;
  state_s st_next;

  function automatic logic canonical(input logic [63:0] a);
    logic ok;
    ok = 1'b1;
    for (int i = VA_BITS - 1; i < 64; i++)
    begin
      if (a[i] != a[VA_BITS-1])
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Gate field decode
  logic [3:0] g_type;
  logic g_s;
  logic [63:0] g_off;
  logic [15:0] g_sel;
  logic [2:0] g_sidx;
  logic g_legal;
  logic g_upper_bad;
  fault_kind_e chk_kind;
  logic [15:0] chk_code;
  logic sys_ill;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;

  assign g_type = gate_lo[TYPE_LSB +: 4];
  assign g_s = gate_lo[S_BIT];
  assign g_sel = gate_lo[SEL_LSB +: 16];
  assign g_off = {gate_hi[OFS2_LSB +: 32], gate_lo[OFS1_LSB +: 16], gate_lo[OFS0_LSB +: 16]};
  assign g_sidx = req_is_int ? gate_lo[SIDX_LSB +: 3] : 3'h0;
  assign g_upper_bad = !req_is_int && (gate_hi[HI_ZERO_LSB +: HI_ZERO_W] != 5'h00);
  assign sys_ill = !(sys_type == TYPE_LDT || sys_type == TYPE_TSS_AVL
                     || sys_type == TYPE_TSS_BUSY);

  always_comb
  begin
    g_legal = 1'b0;
    if (!g_s)
    begin
      if (req_is_int)
      begin
        g_legal = (g_type == TYPE_INT64) || (g_type == TYPE_TRAP64);
      end
      else
      begin
        g_legal = (g_type == TYPE_CALL64);
      end
    end
    chk_kind = FK_NONE;
    chk_code = 16'h0000;
    if (!long_mode)
    begin
      if (!g_s && g_type == TYPE_ZERO)
      begin
        chk_kind = FK_UPPER;
        chk_code = req_gate_code;
      end
    end
    else if (!g_legal)
    begin
      chk_kind = FK_TYPE;
      chk_code = req_gate_code;
    end
    else if (g_upper_bad)
    begin
      chk_kind = FK_UPPER;
      chk_code = req_gate_code;
    end
    else if (!canonical(g_off))
    begin
      chk_kind = FK_CANON;
      chk_code = 16'h0000;
    end
    else if (!(target_cs_l && !target_cs_d))
    begin
      chk_kind = FK_TARGET;
      chk_code = req_is_int ? {8'h00, req_vector} : g_sel;
    end
  end

  always_comb
  begin
    st_next = st_reg;
    ev = '0;
    clr = '0;
    st_next.xfer = 1'b0;
    st_next.fault = 1'b0;
    st_next.sys_done = 1'b0;
    // Write channel
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
    begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case ({st_reg.aw_addr[7:2], 2'b00})
        OFS_TBL_LO: st_next.tbl_base[31:0] = merge(st_reg.tbl_base[31:0], st_reg.w_data,
                                                   st_reg.w_strb);
        OFS_TBL_HI: st_next.tbl_base[63:32] = merge(st_reg.tbl_base[63:32], st_reg.w_data,
                                                    st_reg.w_strb);
        OFS_STATUS: clr = st_reg.w_strb[0] ? st_reg.w_data[ST_W-1:0] : '0;
        OFS_MASK: st_next.mask = st_reg.w_strb[0] ? st_reg.w_data[ST_W-1:0] : st_reg.mask;
        OFS_FAULT: st_next.bresp = RESP_OKAY;
        default: st_next.bresp = RESP_DECERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Read channel
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_TBL_LO: st_next.rdata = st_reg.tbl_base[31:0];
        OFS_TBL_HI: st_next.rdata = st_reg.tbl_base[63:32];
        OFS_STATUS: st_next.rdata = {27'h0, st_reg.status};
        OFS_MASK: st_next.rdata = {27'h0, st_reg.mask};
        OFS_FAULT: st_next.rdata = {13'h0, st_reg.last_kind, st_reg.last_code};
        default:
        begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = RESP_DECERR;
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    // Gate check takes priority over a system descriptor check
    if (req_valid)
    begin
      if (req_is_int)
      begin
        st_next.tbl_addr = st_reg.tbl_base + {52'h0, req_vector, 4'h0};
      end
      if (chk_kind != FK_NONE)
      begin
        st_next.fault = 1'b1;
        st_next.fkind = chk_kind;
        st_next.fcode = chk_code;
      end
      else
      begin
        st_next.xfer = 1'b1;
        st_next.offset = long_mode ? g_off : {32'h0, g_off[31:0]};
        st_next.selector = g_sel;
        st_next.sidx = long_mode ? g_sidx : 3'h0;
        st_next.use_sidx = long_mode && (g_sidx != 3'h0);
        st_next.legacy_stack = req_is_int && !(long_mode && (g_sidx != 3'h0));
      end
    end
    else if (sys_valid)
    begin
      if (long_mode && sys_ill)
      begin
        st_next.fault = 1'b1;
        st_next.fkind = FK_SYSTEM;
        st_next.fcode = sys_selector;
      end
      else
      begin
        st_next.sys_done = 1'b1;
        st_next.sys_expanded = long_mode && cur_cs_l;
      end
    end
    if (st_next.fault)
    begin
      st_next.last_kind = st_next.fkind;
      st_next.last_code = st_next.fcode;
      case (st_next.fkind)
        FK_TYPE: ev[ST_TYPE] = 1'b1;
        FK_UPPER: ev[ST_UPPER] = 1'b1;
        FK_CANON: ev[ST_CANON] = 1'b1;
        FK_TARGET: ev[ST_TARGET] = 1'b1;
        FK_SYSTEM: ev[ST_SYSTEM] = 1'b1;
        default: ev = '0;
      endcase
    end
    st_next.status = (st_reg.status & ~clr) | ev;
    st_next.irq = |(st_next.status & st_next.mask);
    // Code segment size decode
    st_next.mode_64 = long_mode && cur_cs_l;
    st_next.a64_o32 = long_mode && cur_cs_l && !cur_cs_d;
    st_next.size_rsv = long_mode && cur_cs_l && cur_cs_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.tbl_base <= TBL_BASE_RST;
      st_reg.mask <= MASK_RST;
      st_reg.last_kind <= FK_NONE;
      st_reg.fkind <= FK_NONE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign xfer_valid = st_reg.xfer;
  assign xfer_offset = st_reg.offset;
  assign xfer_selector = st_reg.selector;
  assign xfer_sidx = st_reg.sidx;
  assign xfer_use_sidx = st_reg.use_sidx;
  assign xfer_legacy_stack = st_reg.legacy_stack;
  assign tbl_entry_addr = st_reg.tbl_addr;
  assign sys_done = st_reg.sys_done;
  assign sys_expanded = st_reg.sys_expanded;
  assign fault_valid = st_reg.fault;
  assign fault_kind = st_reg.fkind;
  assign fault_code = st_reg.fcode;
  assign mode_64bit = st_reg.mode_64;
  assign addr64_op32 = st_reg.a64_o32;
  assign size_reserved = st_reg.size_rsv;
  assign irq = st_reg.irq;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_type_fault;
    req_valid && long_mode && !g_s && g_type >= TYPE_CALL16 && g_type <= TYPE_TRAP16
      |=> fault_valid && fault_kind == FK_TYPE;
  endproperty
  a_type_fault: assert property (p_type_fault) else $error("legacy gate type passed");

  property p_suppress;
    fault_valid |-> !xfer_valid;
  endproperty
  a_suppress: assert property (p_suppress) else $error("transfer beside fault");

  property p_canon_code;
    req_valid && chk_kind == FK_CANON |=> fault_valid && fault_code == 16'h0000;
  endproperty
  a_canon_code: assert property (p_canon_code) else $error("canonical fault code");

  property p_target_code;
    req_valid && long_mode && req_is_int && chk_kind == FK_TARGET
      |=> fault_kind == FK_TARGET && fault_code == {8'h00, $past(req_vector)};
  endproperty
  a_target_code: assert property (p_target_code) else $error("target fault code");

  property p_tbl_addr;
    req_valid && req_is_int
      |=> tbl_entry_addr == $past(st_reg.tbl_base) + {52'h0, $past(req_vector), 4'h0};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table entry address");

  property p_offset;
    req_valid && long_mode && chk_kind == FK_NONE
      |=> xfer_valid && xfer_offset == {$past(gate_hi[31:0]), $past(gate_lo[63:48]),
                                        $past(gate_lo[15:0])};
  endproperty
  a_offset: assert property (p_offset) else $error("target offset assembly");

  property p_call_no_sidx;
    req_valid && !req_is_int && chk_kind == FK_NONE |=> xfer_sidx == 3'h0 && !xfer_use_sidx;
  endproperty
  a_call_no_sidx: assert property (p_call_no_sidx) else $error("call gate stack index");

  property p_stack_path;
    xfer_valid |-> (xfer_use_sidx == (xfer_sidx != 3'h0)) && !(xfer_use_sidx && xfer_legacy_stack);
  endproperty
  a_stack_path: assert property (p_stack_path) else $error("stack path select");

  property p_sys_illegal;
    !req_valid && sys_valid && long_mode && (sys_type == TYPE_SYS_ILL1 || sys_type ==
      TYPE_SYS_ILL3) |=> fault_valid && fault_kind == FK_SYSTEM && !sys_done;
  endproperty
  a_sys_illegal: assert property (p_sys_illegal) else $error("illegal system type");

  property p_size_rsv;
    long_mode && cur_cs_l && cur_cs_d |=> size_reserved && mode_64bit && !addr64_op32;
  endproperty
  a_size_rsv: assert property (p_size_rsv) else $error("reserved size decode");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

  c_target: cover property (fault_valid && fault_kind == FK_TARGET);
  c_sidx: cover property (xfer_valid && xfer_use_sidx);
  c_sys: cover property (sys_done && sys_expanded);
  c_irq: cover property (s_axi_bvalid ##1 irq);
endmodule

// ===== dv/core_seq_model.sv
// Model of the core sequencer that issues gate and system descriptor checks.
// Assumes its tasks are called just after a rising aclk edge.
module core_seq_model
  import gate_check_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Gate request
  output logic req_valid,
  output logic req_is_int,
  output logic [7:0] req_vector,
  output logic [15:0] req_gate_code,
  output logic [63:0] gate_lo,
  output logic [63:0] gate_hi,
  output logic target_cs_l,
  output logic target_cs_d,
  // System request
  output logic sys_valid,
  output logic [3:0] sys_type,
  output logic [15:0] sys_selector
);
  initial
  begin
    {req_valid, req_is_int, req_vector, req_gate_code, target_cs_l, target_cs_d} = '0;
    {gate_lo, gate_hi, sys_valid, sys_type, sys_selector} = '0;
  end

  task automatic gate(input logic ii, input logic [3:0] ty, input logic [63:0] o,
    input logic [15:0] sel, input logic [2:0] sx, input logic [4:0] hz,
    input logic [7:0] v, input logic [15:0] c, input logic tl, input logic td);
    req_valid <= 1'b1;
    sys_valid <= 1'b0;
    req_is_int <= ii;
    req_vector <= v;
    req_gate_code <= c;
    gate_lo <= {o[31:16], 4'h8, ty, 5'h00, ii ? sx : 3'h0, sel, o[15:0]};
    gate_hi <= {19'h0, hz, 8'h00, o[63:32]};
    target_cs_l <= tl;
    target_cs_d <= td;
    @(posedge aclk);
  endtask

  task automatic sys(input logic [3:0] t, input logic [15:0] s);
    req_valid <= 1'b0;
    sys_valid <= 1'b1;
    sys_type <= t;
    sys_selector <= s;
    @(posedge aclk);
  endtask

  // Released lines show no stale image
  task automatic idle();
    req_valid <= 1'b0;
    sys_valid <= 1'b0;
    gate_lo <= ~gate_lo;
    gate_hi <= ~gate_hi;
    sys_selector <= ~sys_selector;
    @(posedge aclk);
  endtask
endmodule

// ===== dv/gate_checker_tb.sv
// Self-checking bench for the long-mode gate descriptor checker.
// Assumes the core model issues requests; this bench drives the register bus.
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module gate_checker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gate_check_pkg::*;
  localparam int VA = 48;
  typedef struct packed {
    logic [2:0] cls;
    logic lm;
    logic is_int;
    logic [63:0] ofs;
    logic [15:0] sel;
    logic [2:0] sx;
    logic use_sx;
    logic leg;
    logic [63:0] tbl;
    fault_kind_e kind;
    logic [15:0] code;
    logic sysx;
  } exp_s;
  logic aclk, aresetn, long_mode, cur_cs_l, cur_cs_d;
  logic [7:0] s_axi_awaddr, s_axi_araddr, req_vector;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb, sys_type;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic req_valid, req_is_int, target_cs_l, target_cs_d, sys_valid;
  logic [15:0] req_gate_code, sys_selector, xfer_selector, fault_code;
  logic [63:0] gate_lo, gate_hi, xfer_offset, tbl_entry_addr, base;
  logic xfer_valid, xfer_use_sidx, xfer_legacy_stack, sys_done, sys_expanded, fault_valid;
  logic [2:0] xfer_sidx;
  fault_kind_e fault_kind;
  logic mode_64bit, addr64_op32, size_reserved, irq;
  int failures, check_count, cycles;
  int seed = 32'h500d;
  exp_s eq[$];
  exp_s e, last;
  logic [33:0] rq[$];
  logic [33:0] rx;
  logic [63:0] co [5] = '{64'h00007FFFFFFFFFFF, 64'h0000800000000000, 64'hFFFF800000000000,
    64'hFFFF7FFFFFFFFFFF, 64'h8000000000000000};

  gate_checker #(.VA_BITS(VA)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .long_mode, .cur_cs_l,
    .cur_cs_d, .req_valid, .req_is_int, .req_vector, .req_gate_code, .gate_lo, .gate_hi,
    .target_cs_l, .target_cs_d, .sys_valid, .sys_type, .sys_selector, .xfer_valid,
    .xfer_offset, .xfer_selector, .xfer_sidx, .xfer_use_sidx, .xfer_legacy_stack,
    .tbl_entry_addr, .sys_done, .sys_expanded, .fault_valid, .fault_kind, .fault_code,
    .mode_64bit, .addr64_op32, .size_reserved, .irq);

  core_seq_model core (.aclk, .req_valid, .req_is_int, .req_vector, .req_gate_code,
    .gate_lo, .gate_hi, .target_cs_l, .target_cs_d, .sys_valid, .sys_type, .sys_selector);

  always #5 aclk = ~aclk;

  function automatic logic [63:0] cano(input logic [63:0] x);
    return 64'($signed(x << (64 - VA)) >>> (64 - VA));
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic endtest(input string n);
    $display("test %s done", n);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
      @(posedge aclk);
    while (!s_axi_bvalid);
    `CHK(s_axi_bresp, resp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    rq.push_back({resp, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
  endtask

  task automatic mode(input logic lm, input logic l, input logic d);
    long_mode <= lm;
    cur_cs_l <= l;
    cur_cs_d <= d;
    core.idle();
  endtask

  task automatic go(input logic ii, input logic [3:0] ty, input logic [63:0] o,
    input logic [2:0] sx, input logic [4:0] hz, input logic tl, input logic td);
    exp_s x;
    logic [15:0] s, c;
    logic [7:0] v;
    s = 16'($random(seed));
    c = 16'($random(seed));
    v = 8'($random(seed));
    x = '0;
    x.cls = 3'b001;
    x.lm = long_mode;
    x.is_int = ii;
    x.ofs = long_mode ? o : {32'h0, o[31:0]};
    x.sel = s;
    x.sx = (long_mode && ii) ? sx : 3'h0;
    x.use_sx = x.sx != 3'h0;
    x.leg = ii && x.sx == 3'h0;
    x.tbl = base + {52'h0, v, 4'h0};
    x.code = c;
    if (!long_mode)
      x.kind = (ty == TYPE_ZERO) ? FK_UPPER : FK_NONE;
    else if (ii ? (ty != TYPE_INT64 && ty != TYPE_TRAP64) : ty != TYPE_CALL64)
      x.kind = FK_TYPE;
    else if (!ii && hz != 5'h0)
      x.kind = FK_UPPER;
    else if (o != cano(o))
    begin
      x.kind = FK_CANON;
      x.code = 16'h0;
    end
    else if (!(tl && !td))
    begin
      x.kind = FK_TARGET;
      x.code = ii ? {8'h0, v} : s;
    end
    if (x.kind != FK_NONE)
      x.cls = 3'b010;
    last = x;
    eq.push_back(x);
    core.gate(ii, ty, o, s, sx, hz, v, c, tl, td);
  endtask

  task automatic sy(input logic [3:0] t);
    exp_s x;
    logic [15:0] s;
    s = 16'($random(seed));
    x = '0;
    x.cls = 3'b100;
    x.sysx = long_mode & cur_cs_l;
    if (long_mode && !(t == TYPE_LDT || t == TYPE_TSS_AVL || t == TYPE_TSS_BUSY))
    begin
      x.cls = 3'b010;
      x.kind = FK_SYSTEM;
      x.code = s;
    end
    eq.push_back(x);
    core.sys(t, s);
  endtask

  task automatic irqchk(input logic x);
    repeat (3) @(posedge aclk);
    `CHK(irq, x)
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      failures++;
      conclude();
    end
  end

  always @(posedge aclk)
  begin
    if (aresetn && (xfer_valid || fault_valid || sys_done))
    begin
      e = eq.pop_front();
      `CHK({sys_done, fault_valid, xfer_valid}, e.cls)
      if (e.cls[0])
      begin
        `CHK(xfer_offset, e.ofs)
        `CHK(xfer_selector, e.sel)
        `CHK({xfer_sidx, xfer_use_sidx}, {e.sx, e.use_sx})
      end
      if (e.cls[0] && e.lm)
        `CHK(xfer_legacy_stack, e.leg)
      if (e.cls[1])
      begin
        `CHK(fault_kind, e.kind)
        `CHK(fault_code, e.code)
      end
      if (e.cls[2])
        `CHK(sys_expanded, e.sysx)
      if (e.is_int && e.lm)
        `CHK(tbl_entry_addr, e.tbl)
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rx = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, rx)
    end
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {long_mode, cur_cs_l, cur_cs_d} = '0;
    base = TBL_BASE_RST;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(8'(i * 4), 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_DECERR);
    wr(8'h14, 32'h1, RESP_DECERR);
    base = {$random(seed), $random(seed)};
    wr(OFS_TBL_LO, base[31:0], RESP_OKAY);
    wr(OFS_TBL_HI, base[63:32], RESP_OKAY);
    rd(OFS_TBL_LO, base[31:0], RESP_OKAY);
    rd(OFS_TBL_HI, base[63:32], RESP_OKAY);
    endtest("registers");
    for (int lm = 0; lm < 2; lm++)
    begin
      mode(lm[0], 1'b1, 1'b0);
      for (int t = 0; t < 32; t++)
        go(t[0], t[4:1], cano({$random(seed), $random(seed)}), t[3:1], 5'h0, 1'b1, 1'b0);
    end
    endtest("types");
    mode(1'b1, 1'b0, 1'b0);
    repeat (24)
    begin
      r = $random(seed);
      go(r[0], r[0] ? {3'b111, r[1]} : TYPE_CALL64, cano({$random(seed), $random(seed)}),
        r[4:2], 5'h0, 1'b1, 1'b0);
      if (r[5])
        core.idle();
    end
    endtest("offsets");
    for (int b = 0; b < 5; b++)
      go(1'b0, TYPE_CALL64, 64'h1234, 3'h0, 5'h1 << b, 1'b1, 1'b0);
    go(1'b1, TYPE_INT64, 64'h1234, 3'h0, 5'h1F, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++)
      go(i[0], i[0] ? TYPE_INT64 : TYPE_CALL64, co[i / 2], 3'h2, 5'h0, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++)
      go(k[2], k[2] ? TYPE_TRAP64 : TYPE_CALL64, 64'h40, 3'h1, 5'h0, k[1], k[0]);
    endtest("faults");
    for (int k = 0; k < 3; k++)
    begin
      mode(k > 0, k == 2, 1'b0);
      for (int t = 0; t < 16; t++)
        sy(t[3:0]);
    end
    endtest("system");
    for (int k = 0; k < 4; k++)
    begin
      mode(1'b1, k[1], k[0]);
      core.idle();
      `CHK({mode_64bit, addr64_op32, size_reserved}, {k[1], k[1] & !k[0], k[1] & k[0]})
    end
    endtest("decode");
    rd(OFS_STATUS, 32'h1F, RESP_OKAY);
    irqchk(1'b0);
    wr(OFS_MASK, 32'h1F, RESP_OKAY);
    rd(OFS_MASK, 32'h1F, RESP_OKAY);
    irqchk(1'b1);
    wr(OFS_STATUS, 32'h1F, RESP_OKAY);
    irqchk(1'b0);
    go(1'b1, TYPE_CALL64, 64'h80, 3'h0, 5'h0, 1'b1, 1'b0);
    core.idle();
    irqchk(1'b1);
    rd(OFS_FAULT, {13'h0, last.kind, last.code}, RESP_OKAY);
    wr(OFS_FAULT, 32'hFFFF, RESP_OKAY);
    rd(OFS_FAULT, {13'h0, last.kind, last.code}, RESP_OKAY);
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_MASK, 32'h1E, RESP_OKAY);
    irqchk(1'b0);
    endtest("interrupt");
    repeat (4) @(posedge aclk);
    `CHK(eq.size() + rq.size(), 0)
    conclude();
  end
endmodule
